// >>> logic/ebsc_pkg.sv
// shared constants of the external bus state controller
package ebsc_pkg;
    // memory type codes of the area bus control fields
    localparam logic [2:0] TYPE_NORMAL = 3'h0;
    localparam logic [2:0] TYPE_MPX    = 3'h2;
    localparam logic [2:0] TYPE_SDRAM  = 3'h4;
    // bus width field codes
    localparam logic [1:0] BSZ_16 = 2'h2;
    localparam logic [1:0] BSZ_32 = 2'h3;
    // row and column width bases (field adds 0..2)
    localparam logic [4:0] ROW_BASE = 5'h0b;
    localparam logic [4:0] COL_BASE = 5'h08;
    localparam logic [4:0] AP_BASE  = 5'h0a;
    // highest muxed address pin; pins above pass straight
    localparam int ADDR_W   = 26;
    localparam int MUX_TOP  = 17;
    // area numbers, also chip select indices
    localparam logic [1:0] AREA0  = 2'h0;
    localparam logic [1:0] AREA2  = 2'h1;
    localparam logic [1:0] AREA3  = 2'h2;
    localparam logic [1:0] AREA5B = 2'h3;
    // dram command codes on dcmd_code
    localparam logic [3:0] CMD_NOP   = 4'h0;
    localparam logic [3:0] CMD_REF   = 4'h1;
    localparam logic [3:0] CMD_SELF  = 4'h2;
    localparam logic [3:0] CMD_PALL  = 4'h3;
    localparam logic [3:0] CMD_PRE   = 4'h4;
    localparam logic [3:0] CMD_ACTV  = 4'h5;
    localparam logic [3:0] CMD_READ  = 4'h6;
    localparam logic [3:0] CMD_READA = 4'h7;
    localparam logic [3:0] CMD_WRIT  = 4'h8;
    localparam logic [3:0] CMD_WRITA = 4'h9;
    localparam logic [3:0] CMD_MRS   = 4'ha;
    // read data latency after a read command, in cycles
    localparam int CAS_LAT_DEF = 2;
endpackage : ebsc_pkg

// >>> logic/ebsc_addr_mux.sv
// row and column address multiplexer for the dram areas
`timescale 1ns/100ps
module ebsc_addr_mux import ebsc_pkg::*; (
    // access address and geometry
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [1:0]        bus_width_field,
    input  wire logic [1:0]        row_width_field,
    input  wire logic [1:0]        col_width_field,
    input  wire logic              auto_pre,
    // multiplexed pin values
    output logic      [ADDR_W-1:0] row_addr,
    output logic      [ADDR_W-1:0] col_addr
);
    // pin k carries bit k+columns in the row phase; bank pins sit just
    // above the row bits, precharge flag on dram line 10
    always_comb begin
        logic [4:0]        sh;
        logic [4:0]        ncol;
        logic [4:0]        bank;
        logic [4:0]        ap;
        logic [ADDR_W-1:0] shifted;
        sh      = (bus_width_field == BSZ_16) ? 5'h01 : 5'h02;
        ncol    = COL_BASE + {3'h0, col_width_field};
        bank    = ROW_BASE + {3'h0, row_width_field} + sh;
        ap      = AP_BASE + sh;
        shifted = addr >> ncol;
        row_addr = {addr[ADDR_W-1:MUX_TOP+1], shifted[MUX_TOP:0]};
        col_addr = addr;
        col_addr[bank]        = shifted[bank];
        col_addr[bank+5'h01]  = shifted[bank+5'h01];
        col_addr[ap]          = auto_pre;
    end
endmodule : ebsc_addr_mux

// >>> logic/ebsc_ctrl.sv
// external bus state controller: normal, multiplexed and dram areas
// Function
// - setup field adds cycles between chip select and read/write strobes
// - hold field keeps chip select after strobes are released
// - added cycles keep strobes idle, chip select and address driven
// - write data stays driven through the trailing hold cycles
// - multiplexed mode only for type 010 on area 5b
// - multiplexed access: two address cycles then a normal data phase
// - shared bus floats first address cycle, carries address after
// - extra-cycle bit lengthens the address phase to three cycles
// - direction line with chip select: high read, low write
// - dram interface only for type 100 on areas 2 or 3
// - 11-13 row, 8-10 column bits, four banks, line 10 precharge
// - two dram areas share strobes, differ only by chip select
// - dram area data width is 32 or 16 bits
// - burst length one for reads and writes
// - dram commands encoded on row, column, direction and address
// - four byte lane masks select the bytes of a dram access
// - address pins 25 to 18 always carry the raw address
// - 16-bit dram: dram line 0 wired to address pin 1
// - 32-bit dram: dram line 0 wired to address pin 2
// - row pin k gets bit k+columns; column keeps bank, precharge pin
// - zero-wait normal access takes two cycles, bus start first only
// - precharge flag driven as the column command needs
`timescale 1ns/100ps
module ebsc_ctrl import ebsc_pkg::*; #(
    parameter int CAS_LAT = CAS_LAT_DEF
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // configuration
    input  wire logic              setup_count_hi,
    input  wire logic              setup_count_lo,
    input  wire logic              hold_count_hi,
    input  wire logic              hold_count_lo,
    input  wire logic              ext_wait_mask,
    input  wire logic [2:0]        area2_type_code,
    input  wire logic [2:0]        area3_type_code,
    input  wire logic [2:0]        area5b_type_code,
    input  wire logic              muxed_addr_extra_cycle,
    input  wire logic [1:0]        bus_width_field,
    input  wire logic [1:0]        row_width_field,
    input  wire logic [1:0]        col_width_field,
    input  wire logic              auto_precharge,
    // access request
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [1:0]        req_area,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [31:0]       req_wdata,
    input  wire logic [3:0]        req_be,
    // dram control command request
    input  wire logic              dcmd_valid,
    input  wire logic [3:0]        dcmd_code,
    input  wire logic [1:0]        dcmd_area,
    input  wire logic [ADDR_W-1:0] dcmd_addr,
    // answer
    output logic                   req_ready,
    output logic                   req_done,
    output logic [31:0]            rd_data,
    // external bus pins
    input  wire logic              wait_n,
    input  wire logic [31:0]       data_in,
    output logic [31:0]            data_out,
    output logic                   data_oe_n,
    output logic [ADDR_W-1:0]      addr_out,
    output logic [3:0]             area_chip_select_n,
    output logic                   bus_start_n,
    output logic                   rd_n,
    output logic                   rd_wr,
    output logic                   addr_latch_strobe_n,
    output logic                   lane_mask_3_n,
    output logic                   lane_mask_2_n,
    output logic                   lane_mask_1_n,
    output logic                   lane_mask_0_n,
    output logic                   row_strobe_upper_n,
    output logic                   row_strobe_lower_n,
    output logic                   col_strobe_upper_n,
    output logic                   col_strobe_lower_n,
    output logic                   dram_clk_en
);
    if (CAS_LAT < 1 || CAS_LAT > 4) begin : g_chk
        $error("CAS_LAT must be 1 to 4");
    end

    typedef enum logic [3:0] {
        S_IDLE, S_AF, S_AD1, S_AD2, S_LEAD, S_T1, S_T2, S_TRAIL,
        S_ACT, S_GAP, S_CMD, S_CAS
    } ebsc_state_t;

    typedef enum logic [1:0] {M_NORM, M_MPX, M_SDR, M_CTL} ebsc_mode_t;

    typedef struct packed {
        ebsc_state_t       st;
        ebsc_mode_t        mode;
        logic [1:0]        cnt;
        logic [1:0]        area;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic [3:0]        be;
        logic [3:0]        dcode;
        logic [3:0]        cs_n;
        logic [ADDR_W-1:0] addr_o;
        logic [31:0]       dq_o;
        logic              dq_oe_n;
        logic              rd_n;
        logic [3:0]        we_n;
        logic              ah_n;
        logic              bs_n;
        logic              rd_wr;
        logic              ras_n;
        logic              cas_n;
        logic              cke;
        logic [31:0]       rdata;
        logic              done;
        logic              ready;
    } ebsc_regs_t;

    ebsc_regs_t r_r;
    ebsc_regs_t r_nxt;

    logic [1:0]        setup_n;
    logic [1:0]        hold_n;
    logic [ADDR_W-1:0] row_addr;
    logic [ADDR_W-1:0] col_addr;
    logic              cmd_ap;

    assign setup_n = {setup_count_hi, setup_count_lo};
    assign hold_n  = {hold_count_hi, hold_count_lo};
    assign cmd_ap  = (r_r.dcode == CMD_READA) || (r_r.dcode == CMD_WRITA);

    // one-hot low chip select for an area
    function automatic logic [3:0] cs_of(input logic [1:0] area);
        cs_of = ~(4'h1 << area);
    endfunction : cs_of

    // row strobe, column strobe, direction for a dram command
    function automatic logic [2:0] cmd_pins(input logic [3:0] code);
        case (code)
            CMD_REF, CMD_SELF:   cmd_pins = 3'h1;
            CMD_PALL, CMD_PRE:   cmd_pins = 3'h2;
            CMD_ACTV:            cmd_pins = 3'h3;
            CMD_READ, CMD_READA: cmd_pins = 3'h5;
            CMD_WRIT, CMD_WRITA: cmd_pins = 3'h4;
            CMD_MRS:             cmd_pins = 3'h0;
            default:             cmd_pins = 3'h7;
        endcase
    endfunction : cmd_pins

    ebsc_addr_mux u_mux (
        .addr            (r_r.st == S_IDLE ? req_addr : r_r.addr),
        .bus_width_field (bus_width_field),
        .row_width_field (row_width_field),
        .col_width_field (col_width_field),
        .auto_pre        (cmd_ap),
        .row_addr        (row_addr),
        .col_addr        (col_addr)
    );

    // next state and next pin values
    always_comb begin
        ebsc_state_t data_st;
        logic [2:0]  pins;
        data_st = (setup_n != 2'h0) ? S_LEAD : S_T1;
        pins    = 3'h7;
        r_nxt       = r_r;
        r_nxt.done  = 1'b0;
        // sequencing
        case (r_r.st)
            S_IDLE: begin
                if (dcmd_valid) begin
                    r_nxt.mode  = M_CTL;
                    r_nxt.area  = dcmd_area;
                    r_nxt.dcode = dcmd_code;
                    r_nxt.addr  = dcmd_addr;
                    r_nxt.st    = S_CMD;
                end else if (req_valid) begin
                    r_nxt.area  = req_area;
                    r_nxt.wr    = req_write;
                    r_nxt.addr  = req_addr;
                    r_nxt.wdata = req_wdata;
                    r_nxt.be    = req_be;
                    r_nxt.cnt   = setup_n - 2'h1;
                    if (req_area == AREA5B &&
                        area5b_type_code == TYPE_MPX) begin
                        r_nxt.mode = M_MPX;
                        r_nxt.st   = S_AF;
                    end else if ((req_area == AREA2 &&
                                  area2_type_code == TYPE_SDRAM) ||
                                 (req_area == AREA3 &&
                                  area3_type_code == TYPE_SDRAM)) begin
                        r_nxt.mode = M_SDR;
                        r_nxt.st   = S_ACT;
                        if (req_write) begin
                            r_nxt.dcode = auto_precharge ? CMD_WRITA
                                                         : CMD_WRIT;
                        end else begin
                            r_nxt.dcode = auto_precharge ? CMD_READA
                                                         : CMD_READ;
                        end
                    end else begin
                        r_nxt.mode = M_NORM;
                        r_nxt.st   = data_st;
                    end
                end
            end
            S_AF:  r_nxt.st = S_AD1;
            S_AD1: r_nxt.st = muxed_addr_extra_cycle ? S_AD2 : data_st;
            S_AD2: r_nxt.st = data_st;
            S_LEAD: begin
                if (r_r.cnt == 2'h0) begin
                    r_nxt.st = S_T1;
                end else begin
                    r_nxt.cnt = r_r.cnt - 2'h1;
                end
            end
            S_T1: r_nxt.st = S_T2;
            S_T2: begin
                // external wait only honoured when not masked
                if (ext_wait_mask || wait_n) begin
                    r_nxt.done = 1'b1;
                    if (!r_r.wr) begin
                        r_nxt.rdata = data_in;
                    end
                    r_nxt.cnt = hold_n - 2'h1;
                    r_nxt.st  = (hold_n != 2'h0) ? S_TRAIL : S_IDLE;
                end
            end
            S_TRAIL: begin
                if (r_r.cnt == 2'h0) begin
                    r_nxt.st = S_IDLE;
                end else begin
                    r_nxt.cnt = r_r.cnt - 2'h1;
                end
            end
            S_ACT: r_nxt.st = S_GAP;
            S_GAP: r_nxt.st = S_CMD;
            S_CMD: begin
                // burst length one: a single beat per command
                if (r_r.mode == M_SDR && !r_r.wr) begin
                    r_nxt.cnt = 2'(CAS_LAT - 1);
                    r_nxt.st  = S_CAS;
                end else begin
                    r_nxt.done = 1'b1;
                    r_nxt.st   = S_IDLE;
                end
            end
            S_CAS: begin
                if (r_r.cnt == 2'h0) begin
                    r_nxt.rdata = data_in;
                    r_nxt.done  = 1'b1;
                    r_nxt.st    = S_IDLE;
                end else begin
                    r_nxt.cnt = r_r.cnt - 2'h1;
                end
            end
            default: r_nxt.st = S_IDLE;
        endcase
        // pin values for the state being entered
        r_nxt.cs_n    = 4'hf;
        r_nxt.dq_oe_n = 1'b1;
        r_nxt.rd_n    = 1'b1;
        r_nxt.we_n    = 4'hf;
        r_nxt.ah_n    = 1'b1;
        r_nxt.bs_n    = 1'b1;
        r_nxt.rd_wr   = 1'b1;
        r_nxt.ras_n   = 1'b1;
        r_nxt.cas_n   = 1'b1;
        r_nxt.ready   = (r_nxt.st == S_IDLE);
        case (r_nxt.st)
            S_AF: begin
                r_nxt.cs_n   = cs_of(r_nxt.area);
                r_nxt.rd_wr  = !r_nxt.wr;
                r_nxt.ah_n   = 1'b0;
                r_nxt.addr_o = r_nxt.addr;
            end
            S_AD1, S_AD2: begin
                r_nxt.cs_n    = cs_of(r_nxt.area);
                r_nxt.rd_wr   = !r_nxt.wr;
                r_nxt.ah_n    = 1'b0;
                r_nxt.dq_o    = {6'h00, r_nxt.addr};
                r_nxt.dq_oe_n = 1'b0;
            end
            S_LEAD, S_TRAIL: begin
                // strobes idle, everything else as in the access
                r_nxt.cs_n    = cs_of(r_nxt.area);
                r_nxt.rd_wr   = !r_nxt.wr;
                r_nxt.addr_o  = r_nxt.addr;
                r_nxt.dq_o    = r_nxt.wdata;
                r_nxt.dq_oe_n = !r_nxt.wr;
            end
            S_T1, S_T2: begin
                r_nxt.bs_n    = (r_nxt.st != S_T1);
                r_nxt.cs_n    = cs_of(r_nxt.area);
                r_nxt.rd_wr   = !r_nxt.wr;
                r_nxt.addr_o  = r_nxt.addr;
                r_nxt.rd_n    = r_nxt.wr;
                r_nxt.we_n    = r_nxt.wr ? ~r_nxt.be : 4'hf;
                r_nxt.dq_o    = r_nxt.wdata;
                r_nxt.dq_oe_n = !r_nxt.wr;
            end
            S_ACT: begin
                r_nxt.cs_n   = cs_of(r_nxt.area);
                r_nxt.ras_n  = 1'b0;
                r_nxt.addr_o = row_addr;
                r_nxt.cke    = 1'b1;
            end
            S_GAP: begin
                r_nxt.cs_n = cs_of(r_nxt.area);
            end
            S_CMD: begin
                pins          = cmd_pins(r_nxt.dcode);
                r_nxt.cs_n    = cs_of(r_nxt.area);
                r_nxt.ras_n   = pins[2];
                r_nxt.cas_n   = pins[1];
                r_nxt.rd_wr   = pins[0];
                r_nxt.cke     = (r_nxt.dcode != CMD_SELF);
                if (r_nxt.mode == M_SDR) begin
                    r_nxt.addr_o  = col_addr;
                    r_nxt.we_n    = ~r_nxt.be;
                    r_nxt.dq_o    = r_nxt.wdata;
                    r_nxt.dq_oe_n = !r_nxt.wr;
                end else begin
                    r_nxt.addr_o = r_nxt.addr;
                end
            end
            S_CAS: begin
                r_nxt.we_n = ~r_nxt.be;
            end
            default: ;
        endcase
    end

    // one register holds all state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            r_r         <= '0;
            r_r.st      <= S_IDLE;
            r_r.mode    <= M_NORM;
            r_r.cs_n    <= 4'hf;
            r_r.dq_oe_n <= 1'b1;
            r_r.rd_n    <= 1'b1;
            r_r.we_n    <= 4'hf;
            r_r.ah_n    <= 1'b1;
            r_r.bs_n    <= 1'b1;
            r_r.rd_wr   <= 1'b1;
            r_r.ras_n   <= 1'b1;
            r_r.cas_n   <= 1'b1;
            r_r.cke     <= 1'b1;
            r_r.ready   <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs straight from the state register
    assign req_ready           = r_r.ready;
    assign req_done            = r_r.done;
    assign rd_data             = r_r.rdata;
    assign data_out            = r_r.dq_o;
    assign data_oe_n           = r_r.dq_oe_n;
    assign addr_out            = r_r.addr_o;
    assign area_chip_select_n  = r_r.cs_n;
    assign bus_start_n         = r_r.bs_n;
    assign rd_n                = r_r.rd_n;
    assign rd_wr               = r_r.rd_wr;
    assign addr_latch_strobe_n = r_r.ah_n;
    assign lane_mask_3_n       = r_r.we_n[3];
    assign lane_mask_2_n       = r_r.we_n[2];
    assign lane_mask_1_n       = r_r.we_n[1];
    assign lane_mask_0_n       = r_r.we_n[0];
    assign row_strobe_upper_n  = r_r.ras_n;
    assign row_strobe_lower_n  = r_r.ras_n;
    assign col_strobe_upper_n  = r_r.cas_n;
    assign col_strobe_lower_n  = r_r.cas_n;
    assign dram_clk_en         = r_r.cke;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_lead_idle;
        r_r.st == S_LEAD |-> r_r.rd_n && r_r.we_n == 4'hf &&
                             r_r.cs_n != 4'hf;
    endproperty
    a_lead_idle: assert property (p_lead_idle)
        else $error("strobe active in lead-in cycle");

    property p_setup_len;
        r_r.st == S_IDLE && r_nxt.st == S_LEAD && r_nxt.cnt == 2'h1
            |=> r_r.st == S_LEAD ##1 r_r.st == S_LEAD ##1 r_r.st == S_T1;
    endproperty
    a_setup_len: assert property (p_setup_len)
        else $error("setup of two cycles not honoured");

    property p_hold_len;
        r_r.st == S_T2 && r_nxt.st == S_TRAIL && r_nxt.cnt == 2'h0
            |=> r_r.cs_n != 4'hf ##1 r_r.cs_n == 4'hf;
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("hold of one cycle not honoured");

    property p_trail_data;
        r_r.st == S_TRAIL && r_r.wr |-> !r_r.dq_oe_n &&
                                        r_r.dq_o == r_r.wdata;
    endproperty
    a_trail_data: assert property (p_trail_data)
        else $error("write data dropped in trailing cycle");

    property p_mpx_seq;
        r_r.st == S_AF |-> r_r.dq_oe_n ##1
            (r_r.st == S_AD1 && !r_r.dq_oe_n);
    endproperty
    a_mpx_seq: assert property (p_mpx_seq)
        else $error("multiplexed address phase wrong");

    property p_muxed_addr_extra_cycle;
        r_r.st == S_AD1 && muxed_addr_extra_cycle |=> r_r.st == S_AD2;
    endproperty
    a_muxed_addr_extra_cycle: assert property (p_muxed_addr_extra_cycle)
        else $error("third address cycle missing");

    property p_rdwr;
        r_r.st inside {S_AF, S_AD1, S_AD2} |-> r_r.rd_wr == !r_r.wr;
    endproperty
    a_rdwr: assert property (p_rdwr)
        else $error("direction line wrong in address phase");

    property p_bs;
        r_r.st == S_T1 |-> !r_r.bs_n ##1 (r_r.bs_n && r_r.st == S_T2);
    endproperty
    a_bs: assert property (p_bs)
        else $error("bus start not one cycle");

    property p_act;
        r_r.st == S_ACT |-> !r_r.ras_n ##2 (r_r.st == S_CMD && !r_r.cas_n);
    endproperty
    a_act: assert property (p_act)
        else $error("activate not followed by column command");

    property p_hi_addr;
        r_r.st inside {S_ACT, S_CMD} && r_r.mode == M_SDR
            |-> r_r.addr_o[25:18] == r_r.addr[25:18];
    endproperty
    a_hi_addr: assert property (p_hi_addr)
        else $error("upper address pins multiplexed");

    c_mpx: cover property (r_r.st == S_AD2 ##1 r_r.st == S_LEAD);
    c_sdr_rd: cover property (r_r.st == S_CAS ##1 r_r.done);
    c_trail: cover property (r_r.st == S_TRAIL && r_r.wr);
endmodule : ebsc_ctrl

// >>> dv/ebsc_far_model.sv
// far-side model: static memory, muxed device or dram
`timescale 1ns/100ps
module ebsc_far_model (
    // memory-side pins
    input  wire logic        clk,
    input  wire logic        bus_start_n,
    input  wire logic        col_strobe_lower_n,
    input  wire logic        rd_wr,
    input  wire logic        data_oe_n,
    input  wire logic [3:0]  area_chip_select_n,
    input  wire logic [25:0] addr_out,
    input  wire logic [1:0]  slow,
    // answer to the controller
    output logic             wait_n,
    output logic [31:0]      data_in
);
    logic [11:0] a_r;
    logic [1:0]  cnt_r = 2'h0;
    logic [31:0] last_r = 32'h0;
    logic        drv;
    // dram reads answer two cycles after the column command
    assign drv = (~&area_chip_select_n | cnt_r == 2'h1) & rd_wr & data_oe_n;
    assign data_in = drv ? {~a_r, 8'h5a, a_r} : ~last_r;
    assign wait_n  = (cnt_r == 2'h0);
    // latch low address at bus start or column command; slow stalls
    always_ff @(posedge clk) begin
        last_r <= data_in;
        if (!bus_start_n || !col_strobe_lower_n) a_r <= addr_out[11:0];
        cnt_r <= !bus_start_n ? slow : !col_strobe_lower_n ? 2'h2 :
                 cnt_r - {1'b0, |cnt_r};
    end
endmodule : ebsc_far_model

// >>> dv/ebsc_ctrl_test.sv
// self-checking bench of the bus state controller
`timescale 1ns/100ps
module ebsc_ctrl_test import ebsc_pkg::*; ;
    logic clk = 1'b0, rstn = 1'b0, setup_count_hi, setup_count_lo;
    logic hold_count_hi, hold_count_lo, ext_wait_mask, auto_precharge;
    logic muxed_addr_extra_cycle, req_valid, req_write, dcmd_valid;
    logic req_ready, req_done, data_oe_n, bus_start_n, rd_n, rd_wr;
    logic addr_latch_strobe_n, lane_mask_3_n, lane_mask_2_n, wait_n;
    logic lane_mask_1_n, lane_mask_0_n, row_strobe_upper_n, dram_clk_en;
    logic row_strobe_lower_n, col_strobe_upper_n, col_strobe_lower_n;
    logic [2:0]  area2_type_code, area3_type_code, area5b_type_code;
    logic [1:0]  bus_width_field, row_width_field, col_width_field;
    logic [1:0]  req_area, dcmd_area, slow;
    logic [3:0]  req_be, dcmd_code, area_chip_select_n, masks;
    logic [25:0] req_addr, dcmd_addr, addr_out;
    logic [31:0] req_wdata, rd_data, data_in, data_out, r, a;
    logic [31:0] lfsr = 32'h4b391ecd;
    logic [2:0]  enc [11] = '{3'h7, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h5,
                              3'h5, 3'h4, 3'h4, 3'h0};
    int          n_fail = 0, n_tests = 0;
    assign masks = {lane_mask_3_n, lane_mask_2_n, lane_mask_1_n,
                    lane_mask_0_n};
    ebsc_ctrl #(.CAS_LAT(2)) i_ebsc_ctrl (.*);
    ebsc_far_model i_ebsc_far_model (.*);
    initial forever #4 clk = ~clk;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // one dram command
    task automatic cmd(input logic [3:0] c, input logic [1:0] ar);
        logic [4:0]  p;
        logic [3:0]  cs;
        logic [25:0] pa;
        logic [2:0]  e;
        @(posedge clk);
        #1;
        e = enc[c];
        {dcmd_code, dcmd_area, dcmd_addr, dcmd_valid} =
            {c, ar, lfsr[25:0], 1'b1};
        for (int k = 0; k < 8 && req_done !== 1'b1; k++) begin
            {p, cs, pa} = {row_strobe_upper_n, row_strobe_lower_n,
                col_strobe_upper_n, col_strobe_lower_n, rd_wr,
                area_chip_select_n, addr_out};
            @(posedge clk);
            #1;
            dcmd_valid = 1'b0;
        end
        chk(p, {e[2], e[2], e[1], e[1], e[0]});
        chk(pa, dcmd_addr);
        if (c != CMD_NOP) chk(cs, {~(4'h1 << ar)});
        chk(dram_clk_en, c != CMD_SELF);
    endtask : cmd
    // one access: lead, strobe and trail cycles counted
    task automatic acc(input logic [1:0] ar, input logic w,
                       input logic [25:0] ad);
        int ld = 0, sb = 0, tr = 0, bs = 0, dn = 0;
        logic [31:0] wd;
        logic [3:0]  be;
        logic        dr, mx, fu;
        wd = rnd();
        be = wd[31:28] | 4'h1;
        dr = (ar == AREA2 && area2_type_code == TYPE_SDRAM) ||
             (ar == AREA3 && area3_type_code == TYPE_SDRAM);
        mx = ar == AREA5B && area5b_type_code == TYPE_MPX;
        fu = {bus_width_field, row_width_field, col_width_field} == 6'h30;
        {req_area, req_write, req_addr, req_wdata, req_be, req_valid} =
            {ar, w, ad, wd, be, 1'b1};
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            #1;
            if (k == 0) req_valid = 1'b0;
            if (!area_chip_select_n[ar] && !dr) begin
                if (w ? masks != 4'hf : !rd_n) begin
                    sb++;
                    if (w) chk(masks, {~be});
                end else if (sb == 0) ld++;
                else tr++;
                if (mx && sb == 0 && ld == 1) chk(data_oe_n, 1'b1);
                if (w && tr > 0) chk(data_out, wd);
                chk(rd_wr, !w);
                if (!mx) chk(addr_out, ad);
            end
            if (dr && !(row_strobe_lower_n && col_strobe_lower_n))
                chk(addr_out[25:18], ad[25:18]);
            if (dr && !row_strobe_lower_n) begin
                chk({area_chip_select_n, row_strobe_upper_n},
                    {~(4'h1 << ar), 1'b0});
                if (fu) chk(addr_out, {ad[25:18], ad[25:8]});
            end
            if (dr && !col_strobe_lower_n) begin
                chk({rd_wr, masks}, {!w, ~be});
                if (fu) chk(addr_out, {ad[25:15], ad[22:21],
                    auto_precharge, ad[11:0]});
            end
            bs += !bus_start_n;
            dn += req_done;
            if (req_ready === 1'b1) break;
        end
        chk(dn, 1);
        if (!w && (!dr || fu))
            chk(rd_data, {~ad[11:0], 8'h5a, ad[11:0]});
        if (!dr) begin
            chk(ld, {setup_count_hi, setup_count_lo} +
                (mx ? 2 + muxed_addr_extra_cycle : 0));
            chk(tr, {hold_count_hi, hold_count_lo});
            chk(sb, 2 + (ext_wait_mask ? 0 : slow));
            chk(bs, 1);
        end
    endtask : acc
    // commands, corner accesses, random traffic
    initial begin
        {setup_count_hi, setup_count_lo, hold_count_hi, hold_count_lo,
         ext_wait_mask, muxed_addr_extra_cycle, auto_precharge, req_valid,
         req_write, dcmd_valid, area5b_type_code, bus_width_field,
         row_width_field, col_width_field, req_area, dcmd_area, slow,
         req_be, dcmd_code, req_addr, dcmd_addr, req_wdata} = '0;
        {area2_type_code, area3_type_code} = {TYPE_SDRAM, TYPE_SDRAM};
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        for (int k = 0; k < 11; k++) cmd(k[3:0], k[0] ? AREA2 : AREA3);
        {setup_count_hi, setup_count_lo, hold_count_hi, hold_count_lo,
         ext_wait_mask, area5b_type_code} = {5'h1f, TYPE_MPX};
        acc(AREA0, 1'b1, 26'h3ffffff);
        acc(AREA5B, 1'b0, 26'h0);
        repeat (300) begin
            r = rnd();
            a = rnd();
            {setup_count_hi, setup_count_lo, hold_count_hi, hold_count_lo,
             ext_wait_mask, muxed_addr_extra_cycle, auto_precharge,
             slow} = r[8:0];
            area2_type_code = r[9] ? TYPE_SDRAM : TYPE_NORMAL;
            area3_type_code = r[10] ? TYPE_SDRAM : TYPE_NORMAL;
            area5b_type_code = r[11] ? TYPE_MPX : TYPE_NORMAL;
            bus_width_field = r[12] | r[15] ? BSZ_32 : BSZ_16;
            row_width_field = r[15] ? 2'h0 : {1'b0, r[13]};
            col_width_field = r[15] ? 2'h0 : {r[14], 1'b0};
            acc(r[17:16], r[18], a[25:0]);
        end
        complete_run();
    end
    // watchdog far beyond the run length
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
endmodule : ebsc_ctrl_test
